/* src/adcsq_top.sv */
// converter sequencing control: pins, start, busy, result, interrupt
`timescale 1ns/100ps
module adcsq_top
    import adcsq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire adcsq_cfg_t cfg,
    input wire logic [3:0] analog_pin_enable_bits,
    input wire logic [3:0] port_a_direction_reg,
    input wire logic [3:0] pull_high_req,
    input wire logic start_bit,
    input wire logic global_interrupt_enable,
    input wire logic converter_irq_enable_bit,
    input wire logic irq_flag_clear,
    input wire logic [ADCSQ_RES_W-1:0] analog_sample,
    output logic [3:0] pin_analog_sel,
    output logic [3:0] pin_digital_en,
    output logic [3:0] pin_dir_input,
    output logic [3:0] pin_pull_high,
    output logic reference_from_pin,
    output logic analog_powered,
    output logic [2:0] mux_channel,
    output logic mux_channel_valid,
    output logic converter_reset,
    output logic conversion_busy_flag,
    output logic [3:0] result_reg_high,
    output logic [7:0] result_reg_low,
    output logic converter_irq_request_flag,
    output logic converter_irq
);
    // ==========================================================
    // internal state
    adcsq_state_t state_q;
    logic start_prev_q;
    logic [4:0] tick_cnt_q;
    logic [3:0] pin_en_q;
    logic tick;
    logic start_rise;
    logic start_fall;
    logic conv_done;
    logic [2:0] chan;

    // channel number from the split select bits
    function automatic logic [2:0] chan_of(input adcsq_cfg_t c);
        chan_of = {c.channel_select_upper, c.channel_select_mid,
                   c.channel_select_low};
    endfunction

    assign chan = chan_of(cfg);
    assign start_rise = start_bit && !start_prev_q;
    assign start_fall = !start_bit && start_prev_q;
    assign conv_done = (state_q == ADCSQ_CONV) && tick
                       && (tick_cnt_q == ADCSQ_TICK_LAST);

    // ==========================================================
    // converter clock
    adcsq_clkdiv u_clkdiv (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .run(state_q == ADCSQ_CONV),
        .div_code(cfg.clock_divider),
        .tick(tick)
    );

    // ==========================================================
    // pin enable copy; all analog after reset
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pin_en_q <= ADCSQ_PIN_EN_RST;
        end
        else if (clk_en)
        begin
            pin_en_q <= analog_pin_enable_bits;
        end
    end

    // pin function override outputs
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pin_analog_sel <= ADCSQ_PIN_EN_RST;
            pin_digital_en <= '0;
            pin_dir_input <= ADCSQ_PIN_EN_RST;
            pin_pull_high <= '0;
        end
        else if (clk_en)
        begin
            pin_analog_sel <= pin_en_q;
            pin_digital_en <= ~pin_en_q;
            pin_dir_input <= pin_en_q | port_a_direction_reg;
            pin_pull_high <= pull_high_req & ~pin_en_q;
        end
    end

    // reference, power and channel routing
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            reference_from_pin <= 1'b0;
            analog_powered <= 1'b0;
            mux_channel <= '0;
            mux_channel_valid <= 1'b0;
        end
        else if (clk_en)
        begin
            reference_from_pin <= cfg.reference_source_select;
            analog_powered <= !cfg.power_off;
            mux_channel <= chan;
            // unbonded channel never feeds a conversion
            mux_channel_valid <= (chan < 3'(ADCSQ_CH_N))
                                 && (chan != ADCSQ_UNBONDED_CH)
                                 && pin_en_q[chan[1:0]];
        end
    end

    // ==========================================================
    // start edge history
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            start_prev_q <= 1'b0;
        end
        else if (clk_en)
        begin
            start_prev_q <= start_bit;
        end
    end

    // sequencer: hold while start high, convert after its fall
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= ADCSQ_IDLE;
        end
        else if (clk_en)
        begin
            case (state_q)
                ADCSQ_IDLE:
                begin
                    if (start_rise)
                    begin
                        state_q <= ADCSQ_HOLD;
                    end
                end
                ADCSQ_HOLD:
                begin
                    if (start_fall && !cfg.power_off)
                    begin
                        state_q <= ADCSQ_CONV;
                    end
                    else if (start_fall)
                    begin
                        state_q <= ADCSQ_IDLE;
                    end
                end
                ADCSQ_CONV:
                begin
                    if (start_rise)
                    begin
                        state_q <= ADCSQ_HOLD;
                    end
                    else if (cfg.power_off || conv_done)
                    begin
                        state_q <= ADCSQ_IDLE;
                    end
                end
                default:
                begin
                    state_q <= ADCSQ_IDLE;
                end
            endcase
        end
    end

    // converter clock periods counted within a conversion
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tick_cnt_q <= '0;
        end
        else if (clk_en)
        begin
            if (state_q != ADCSQ_CONV)
            begin
                tick_cnt_q <= '0;
            end
            else if (tick)
            begin
                tick_cnt_q <= tick_cnt_q + 5'h01;
            end
        end
    end

    // busy flag and converter reset
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            conversion_busy_flag <= 1'b0;
            converter_reset <= 1'b1;
        end
        else if (clk_en)
        begin
            if (start_rise)
            begin
                conversion_busy_flag <= 1'b1;
                converter_reset <= 1'b1;
            end
            else if (state_q == ADCSQ_HOLD && start_fall)
            begin
                converter_reset <= cfg.power_off;
            end
            else if (conv_done)
            begin
                conversion_busy_flag <= 1'b0;
                converter_reset <= 1'b1;
            end
            else if (state_q == ADCSQ_CONV && cfg.power_off)
            begin
                converter_reset <= 1'b1;
            end
        end
    end

    // result registers load in the same edge busy falls
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            result_reg_high <= '0;
            result_reg_low <= '0;
        end
        else if (clk_en && conv_done)
        begin
            result_reg_high <= analog_sample[11:8];
            result_reg_low <= analog_sample[7:0];
        end
    end

    // sticky request flag, set wins over clear
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            converter_irq_request_flag <= 1'b0;
        end
        else if (clk_en)
        begin
            if (conv_done)
            begin
                converter_irq_request_flag <= 1'b1;
            end
            else if (irq_flag_clear)
            begin
                converter_irq_request_flag <= 1'b0;
            end
        end
    end

    // interrupt line gated by both enables
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            converter_irq <= 1'b0;
        end
        else if (clk_en)
        begin
            converter_irq <= (conv_done || converter_irq_request_flag)
                             && global_interrupt_enable
                             && converter_irq_enable_bit;
        end
    end
endmodule

/* src/adcsq_pkg.sv */
// constants and carrier types for the converter sequencing control
// ==========================================================
// How it works
// - enable bit makes pin analog, others off
// - analog pin drops its pull-high resistor
// - enable bit overrides port direction control
// - reference select picks external pin or supply
// - divider codes 0 to 6 halve clock; 7 undefined
// - power-off bit high switches converter off
// - three channel-select bits pick converter input
// - interrupt needs global and converter enables
// - start held high resets converter, busy high
// - busy falling marks valid result registers
// - request flag set at end of conversion
// - conversion lasts sixteen converter clock periods
// - reset makes all analog pins converter inputs
// - fourth channel internal, never a conversion input
// - twelve-bit result, step is reference over 4096
package adcsq_pkg;
    localparam int ADCSQ_CH_N = 4;
    localparam int ADCSQ_RES_W = 12;
    localparam int ADCSQ_CONV_TICKS = 16;
    localparam logic [3:0] ADCSQ_PIN_EN_RST = 4'hF;
    localparam logic [2:0] ADCSQ_DIV_RST = 3'h0;
    localparam logic [2:0] ADCSQ_DIV_MAX = 3'h6;
    localparam logic [2:0] ADCSQ_UNBONDED_CH = 3'h3;
    localparam int ADCSQ_DIV_CNT_W = 6;
    localparam logic [4:0] ADCSQ_TICK_LAST = 5'hF;

    typedef enum logic [2:0] {
        ADCSQ_IDLE = 3'b001,
        ADCSQ_HOLD = 3'b010,
        ADCSQ_CONV = 3'b100
    } adcsq_state_t;

    typedef struct packed {
        logic [2:0] clock_divider;
        logic power_off;
        logic reference_source_select;
        logic channel_select_upper;
        logic channel_select_mid;
        logic channel_select_low;
    } adcsq_cfg_t;

    typedef struct packed {
        logic [ADCSQ_RES_W-1:0] sample;
        logic sample_valid;
    } adcsq_sample_t;
endpackage

/* src/adcsq_clkdiv.sv */
// converter clock tick generator from the system clock
`timescale 1ns/100ps
module adcsq_clkdiv
    import adcsq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic run,
    input wire logic [2:0] div_code,
    output logic tick
);
    // ==========================================================
    // divider counter
    logic [ADCSQ_DIV_CNT_W-1:0] cnt_q;
    logic [ADCSQ_DIV_CNT_W-1:0] last;

    // terminal count is 2**code - 1; code 7 treated as divide-by-64
    always_comb
    begin
        if (div_code > ADCSQ_DIV_MAX)
        begin
            last = '1;
        end
        else
        begin
            last = ADCSQ_DIV_CNT_W'((7'h01 << div_code) - 7'h01);
        end
    end

    assign tick = run && (cnt_q >= last);

    // count system clocks while a conversion runs
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt_q <= '0;
        end
        else if (clk_en)
        begin
            if (!run || tick)
            begin
                cnt_q <= '0;
            end
            else
            begin
                cnt_q <= cnt_q + 6'h01;
            end
        end
    end
endmodule

/* tb/adcsq_src_model.sv */
// analog source model standing on the shared input pins
`timescale 1ns/100ps
module adcsq_src_model
    import adcsq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [2:0] mux_channel,
    input wire logic mux_channel_valid,
    input wire logic analog_powered,
    output logic [ADCSQ_RES_W-1:0] analog_sample
);
    logic [ADCSQ_RES_W-1:0] junk_q = 12'h3C3;
    // an unrouted input wanders every cycle, never a stable value
    always_ff @(posedge ref_clk)
    begin
        junk_q <= ~junk_q ^ 12'h001;
    end
    // a routed, powered pin holds a steady level per channel
    assign analog_sample = (mux_channel_valid && analog_powered) ?
        (12'hA5C ^ {9'h000, mux_channel}) : junk_q;
endmodule

/* tb/adcsq_assertions.sv */
// port-level checks for the converter sequencing control
`timescale 1ns/100ps
module adcsq_assertions
    import adcsq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire adcsq_cfg_t cfg,
    input wire logic start_bit,
    input wire logic irq_flag_clear,
    input wire logic global_interrupt_enable,
    input wire logic converter_irq_enable_bit,
    input wire logic [3:0] pin_analog_sel,
    input wire logic [3:0] pin_digital_en,
    input wire logic [3:0] pin_dir_input,
    input wire logic [3:0] pin_pull_high,
    input wire logic analog_powered,
    input wire logic converter_reset,
    input wire logic conversion_busy_flag,
    input wire logic [3:0] result_reg_high,
    input wire logic [7:0] result_reg_low,
    input wire logic converter_irq_request_flag,
    input wire logic converter_irq
);
    // ==========================================
    // assertions
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);
    pin_mutex_a:
    assert property (pin_digital_en == ~pin_analog_sel)
        else $error("digital path on analog pin");
    pull_off_a:
    assert property ((pin_pull_high & pin_analog_sel) == 4'h0)
        else $error("pull-high on analog pin");
    dir_over_a:
    assert property ((pin_analog_sel & ~pin_dir_input) == 4'h0)
        else $error("analog pin not an input");
    power_ctl_a:
    assert property ($past(nrst) && $past(clk_en) |->
        analog_powered == !$past(cfg.power_off))
        else $error("power state wrong");
    irq_gate_a:
    assert property (converter_irq |-> ($past(converter_irq_request_flag)
        || converter_irq_request_flag) && $past(global_interrupt_enable)
        && $past(converter_irq_enable_bit))
        else $error("irq without enables");
    start_hold_a:
    assert property (start_bit && clk_en |=>
        conversion_busy_flag && converter_reset)
        else $error("start high without hold");
    done_flag_a:
    assert property ($fell(conversion_busy_flag) |->
        converter_irq_request_flag)
        else $error("done without request flag");
    flag_stick_a:
    assert property (converter_irq_request_flag && !irq_flag_clear |=>
        converter_irq_request_flag)
        else $error("request flag lost");
    result_hold_a:
    assert property (!conversion_busy_flag && !$past(conversion_busy_flag)
        |-> $stable({result_reg_high, result_reg_low}))
        else $error("result moved while idle");
    conv_len_a:
    assert property ($fell(converter_reset) && cfg.clock_divider == 3'h0 |->
        conversion_busy_flag [*8] ##1 conversion_busy_flag [*4]
        ##[1:7] !conversion_busy_flag)
        else $error("conversion length wrong");
    // ==========================================
    // scenario coverage
    done_c: cover property ($fell(conversion_busy_flag));
    irq_c: cover property (converter_irq);
    hold_c: cover property (start_bit [*8]);
endmodule

/* tb/testbench.sv */
// self-checking bench for the converter sequencing control
`timescale 1ns/100ps
module testbench
    import adcsq_pkg::*;
;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic clk_en = 1'b1;
    adcsq_cfg_t cfg = '0;
    logic [3:0] analog_pin_enable_bits = 4'hF;
    logic [3:0] port_a_direction_reg = 4'h0;
    logic [3:0] pull_high_req = 4'h0;
    logic start_bit = 1'b0;
    logic global_interrupt_enable = 1'b0;
    logic converter_irq_enable_bit = 1'b0;
    logic irq_flag_clear = 1'b0;
    logic [ADCSQ_RES_W-1:0] analog_sample;
    logic [3:0] pin_analog_sel, pin_digital_en, pin_dir_input, pin_pull_high;
    logic reference_from_pin, analog_powered, mux_channel_valid;
    logic [2:0] mux_channel;
    logic converter_reset, conversion_busy_flag;
    logic [3:0] result_reg_high;
    logic [7:0] result_reg_low;
    logic converter_irq_request_flag, converter_irq;
    logic ok;
    logic [15:0] v;
    int num_errors = 0;
    int checks = 0;
    // rows: enable, direction, pull, then expected select, input, pull
    logic [23:0] rows [6] = '{24'hF0FFF0, 24'h05F05F, 24'h52F57A,
        24'hA05AA5, 24'h3CC3FC, 24'h816896};
    // short views of the status outputs
    wire bsy = conversion_busy_flag;
    wire flg = converter_irq_request_flag;
    wire [11:0] res = {result_reg_high, result_reg_low};

    // ==========================================
    // design, far-side sources and clock
    adcsq_top uut (.ref_clk, .nrst, .clk_en, .cfg, .analog_pin_enable_bits,
        .port_a_direction_reg, .pull_high_req, .start_bit,
        .global_interrupt_enable, .converter_irq_enable_bit,
        .irq_flag_clear, .analog_sample, .pin_analog_sel, .pin_digital_en,
        .pin_dir_input, .pin_pull_high, .reference_from_pin, .analog_powered,
        .mux_channel, .mux_channel_valid, .converter_reset,
        .conversion_busy_flag, .result_reg_high, .result_reg_low,
        .converter_irq_request_flag, .converter_irq);
    adcsq_src_model src_u (.ref_clk, .mux_channel, .mux_channel_valid,
        .analog_powered, .analog_sample);
    // system clock, 8 ns period
    always #4 ref_clk = ~ref_clk;

    // ==========================================
    // tasks
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("checks=%0d errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // one start pulse, then wait for done and check time and result
    task automatic conv(input logic [2:0] code, input logic [11:0] exp);
        int n;
        int s;
        n = 0;
        // code 7 runs like divide-by-64
        s = (code > ADCSQ_DIV_MAX) ? 6 : int'(code);
        cfg.clock_divider = code;
        cyc(2);
        start_bit = 1'b1;
        cyc(1);
        chk({14'h0, bsy, converter_reset}, 16'h0003);
        start_bit = 1'b0;
        while (bsy === 1'b1 && n < 2100)
        begin
            cyc(1);
            n++;
        end
        ok = n >= (15 << s) && n <= (17 << s) + 3;
        chk({15'h0, ok}, 16'h0001);
        chk({bsy, flg, 2'h0, res}, {4'h4, exp});
    endtask

    // ==========================================
    // main sequence
    initial
    begin
        cyc(12);
        v = {pin_analog_sel, pin_dir_input, pin_pull_high, 1'b0,
            converter_reset, bsy, flg};
        chk(v, 16'hFF04);
        nrst = 1'b1;
        $display("reset test done");
        for (int i = 0; i < 6; i++)
        begin
            {analog_pin_enable_bits, port_a_direction_reg, pull_high_req} =
                rows[i][23:12];
            cfg = {3'h0, i[0], i[1], i[2:0]};
            ok = i < 3 && rows[i][20 + i];
            cyc(4);
            v = {pin_analog_sel, pin_dir_input, pin_pull_high,
                analog_powered, reference_from_pin, mux_channel_valid, 1'b0};
            chk(v, {rows[i][11:0], ~i[0], i[1], ok, 1'b0});
            v = {9'h0, pin_digital_en, mux_channel};
            chk(v, {9'h0, ~rows[i][23:20], i[2:0]});
        end
        $display("pin table done");
        {analog_pin_enable_bits, port_a_direction_reg, pull_high_req} = 12'hF00;
        cfg = '0;
        cyc(4);
        for (int c = 0; c < 8; c++)
            conv(c[2:0], 12'hA5C);
        cfg.channel_select_mid = 1'b1;
        conv(3'h0, 12'hA5E);
        chk({15'h0, converter_irq}, 16'h0000);
        $display("conversion test done");
        start_bit = 1'b1;
        cyc(40);
        chk({13'h0, bsy, converter_reset, flg}, 16'h0007);
        start_bit = 1'b0;
        cyc(30);
        chk({15'h0, bsy}, 16'h0000);
        $display("held start test done");
        // frozen enable: a start edge waits until the enable returns
        cfg.clock_divider = 3'h1;
        clk_en = 1'b0;
        start_bit = 1'b1;
        cyc(3);
        chk({14'h0, bsy, converter_reset}, 16'h0001);
        clk_en = 1'b1;
        cyc(1);
        chk({14'h0, bsy, converter_reset}, 16'h0003);
        start_bit = 1'b0;
        cyc(4);
        chk({14'h0, bsy, converter_reset}, 16'h0002);
        // power-off in mid-conversion aborts and resets the converter
        cfg.power_off = 1'b1;
        cyc(2);
        chk({13'h0, bsy, converter_reset, analog_powered}, 16'h0006);
        cfg.power_off = 1'b0;
        cyc(40);
        chk({14'h0, bsy, converter_reset}, 16'h0003);
        $display("freeze and abort test done");
        global_interrupt_enable = 1'b1;
        cyc(3);
        chk({15'h0, converter_irq}, 16'h0000);
        converter_irq_enable_bit = 1'b1;
        cyc(3);
        chk({15'h0, converter_irq}, 16'h0001);
        irq_flag_clear = 1'b1;
        cyc(1);
        irq_flag_clear = 1'b0;
        cyc(3);
        chk({14'h0, flg, converter_irq}, 16'h0000);
        // a conversion finishing with both enables raises the line
        conv(3'h0, 12'hA5E);
        cyc(1);
        chk({15'h0, converter_irq}, 16'h0001);
        $display("interrupt test done");
        end_of_test();
    end
    // watchdog: the run needs about 26 us, so 400 us means a hang
    initial
    begin
        #400000;
        num_errors++;
        $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        end_of_test();
    end
endmodule
bind adcsq_top adcsq_assertions sva_u (.ref_clk, .nrst, .clk_en, .cfg,
    .start_bit, .irq_flag_clear, .global_interrupt_enable,
    .converter_irq_enable_bit, .pin_analog_sel, .pin_digital_en,
    .pin_dir_input, .pin_pull_high, .analog_powered, .converter_reset,
    .conversion_busy_flag, .result_reg_high, .result_reg_low,
    .converter_irq_request_flag, .converter_irq);
